// ==== shared/pcd_regs.svh ====
// Register indices, field positions, reset values and divider codes
// for the peripheral clock divider and oscillator trim block.
// Assumes a 16-bit APB byte address whose bits 15:2 carry the index.
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define PCD_IDX_CRY1 14'h2860
`define PCD_IDX_CRY2 14'h2861
`define PCD_IDX_DIV 14'h2D02
`define PCD_IDX_DIVSTAT 14'h2D03
`define PCD_IDX_ANSTAT 14'h286B

// ********************************************************************
// Reset values
// ********************************************************************
`define PCD_CRY1_RST 8'h00
`define PCD_CRY2_RST 8'h00
`define PCD_DIV_RST 8'h00

// ********************************************************************
// Field positions
// ********************************************************************
`define PCD_CRY1_CAP_BIT 4
`define PCD_CRY1_RES_P_BIT 2
`define PCD_CRY2_LEAK_BIT 7
`define PCD_CRY2_MON_BIT 5
`define PCD_CRY2_BIAS_BIT 4
`define PCD_CRY2_CMPB_HI 3
`define PCD_CRY2_CMPB_LO 2
`define PCD_CRY2_CMPA_HI 1
`define PCD_CRY2_CMPA_LO 0
`define PCD_ANST_OSC_BIT 7
`define PCD_ANST_CMPB_BIT 5

// ********************************************************************
// Divider codes and ratio shifts
// ********************************************************************
`define PCD_DIV_CODE_1 8'h00
`define PCD_DIV_CODE_2 8'h01
`define PCD_DIV_CODE_4 8'h02
`define PCD_DIV_CODE_8 8'h03
`define PCD_DIV_CODE_16 8'h04
`define PCD_SHIFT_1 3'h0
`define PCD_SHIFT_2 3'h1
`define PCD_SHIFT_4 3'h2
`define PCD_SHIFT_8 3'h3
`define PCD_SHIFT_16 3'h4
`define PCD_RES_N_CODE 2'h2

`endif

// ==== shared/pcd_pkg.sv ====
// Types and shared decode functions of the clock divider and trim block.
// Assumes pcd_regs.svh is on the include path.
package pcd_pkg;
  `include "pcd_regs.svh"

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [1:0] {
    PCD_IDLE = 2'b00,
    PCD_SETUP = 2'b01,
    PCD_ACCESS = 2'b11
  } pcd_apb_state_t;

  typedef enum logic {
    PCD_NEG_LOW_POWER_REFERENCE = 1'b0,
    PCD_NEG_PIN = 1'b1
  } pcd_cmp_neg_t;

  typedef enum logic {
    PCD_A_POS_PPIN = 1'b0,
    PCD_A_POS_NPIN = 1'b1
  } pcd_cmpa_pos_t;

  typedef enum logic {
    PCD_B_POS_MET_TWO = 1'b0,
    PCD_B_POS_MET_ONE = 1'b1
  } pcd_cmpb_pos_t;

  // ******************************************************************
  // Functions
  // ******************************************************************
  // Turns a divider register value into a ratio shift.
  function automatic logic [2:0] pcd_div_shift(input logic [7:0] code);
    case (code)
      `PCD_DIV_CODE_2: pcd_div_shift = `PCD_SHIFT_2;
      `PCD_DIV_CODE_4: pcd_div_shift = `PCD_SHIFT_4;
      `PCD_DIV_CODE_8: pcd_div_shift = `PCD_SHIFT_8;
      `PCD_DIV_CODE_16: pcd_div_shift = `PCD_SHIFT_16;
      default: pcd_div_shift = `PCD_SHIFT_1;
    endcase
  endfunction

  // Returns {positive uses alternate, negative uses pin} for a selector.
  function automatic logic [1:0] pcd_cmp_route(input logic [1:0] sel);
    case (sel)
      2'h0: pcd_cmp_route = 2'b00;
      2'h1: pcd_cmp_route = 2'b10;
      default: pcd_cmp_route = 2'b01;
    endcase
  endfunction
endpackage

// ==== src/pcd_clkdiv.sv ====
// Peripheral clock divider counter with glitch-free ratio changes.
// Assumes the requested shift is a static level from the register file.
`include "pcd_regs.svh"
module pcd_clkdiv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] req_shift,
  output logic [2:0] act_shift,
  output logic periph_clk,
  output logic periph_tick
);
  import pcd_pkg::*;

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [2:0] shift_r;
  logic [2:0] shift_nxt;
  logic clk_r;
  logic clk_nxt;
  logic [3:0] limit;
  logic [3:0] limit_nxt;
  logic last;

  // ******************************************************************
  // Counter
  // ******************************************************************
  always_comb begin
    limit = 4'((5'h01 << shift_r) - 5'h01);
    last = (cnt_r == limit);
    if (last) begin
      cnt_nxt = 4'h0;
      shift_nxt = req_shift;
    end else begin
      cnt_nxt = 4'(cnt_r + 4'h1);
      shift_nxt = shift_r;
    end
    limit_nxt = 4'((5'h01 << shift_nxt) - 5'h01);
    if (shift_nxt == `PCD_SHIFT_1) begin
      clk_nxt = 1'b1;
    end else begin
      clk_nxt = (cnt_nxt <= (limit_nxt >> 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      shift_r <= 3'h0;
      clk_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign periph_tick = last;
  assign periph_clk = clk_r;
  assign act_shift = shift_r;
endmodule

// ==== src/pcd_top.sv ====
// APB register file for the peripheral clock divider and the crystal
// oscillator and comparator trims, with the divider itself.
// Assumes an APB master on pclk and trim outputs wired to analog blocks.
`include "pcd_regs.svh"

// ********************************************************************
// Operation
// ********************************************************************
module pcd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_rc_active,
  input wire logic comp_b_out,
  input wire logic ref_leak_detected,
  output logic periph_clk,
  output logic periph_tick,
  output logic load_cap_reduce,
  output logic [2:0] osc_resistor_trim,
  output logic osc_res_p_add,
  output logic osc_res_n_add,
  output logic ref_leak_detect_en,
  output logic ref_leak_irq,
  output logic osc_monitor_en,
  output logic comp_b_bias_sel,
  output pcd_pkg::pcd_cmpb_pos_t comp_b_pos_sel,
  output pcd_pkg::pcd_cmp_neg_t comp_b_neg_sel,
  output pcd_pkg::pcd_cmpa_pos_t comp_a_pos_sel,
  output pcd_pkg::pcd_cmp_neg_t comp_a_neg_sel
);
  import pcd_pkg::*;

  // ******************************************************************
  // Declarations
  // ******************************************************************
  pcd_apb_state_t state_r;
  pcd_apb_state_t state_nxt;
  logic [7:0] cry1_r;
  logic [7:0] cry1_nxt;
  logic [7:0] cry2_r;
  logic [7:0] cry2_nxt;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic err_r;
  logic err_nxt;
  logic [13:0] idx;
  logic aligned;
  logic hit_cry1;
  logic hit_cry2;
  logic hit_div;
  logic hit_divstat;
  logic hit_anstat;
  logic mapped;
  logic read_only;
  logic setup_phase;
  logic wr_en;
  logic [2:0] act_shift;
  logic [1:0] route_a;
  logic [1:0] route_b;

  logic cap_r;
  logic cap_nxt;
  logic [2:0] res_r;
  logic [2:0] res_nxt;
  logic res_p_r;
  logic res_p_nxt;
  logic res_n_r;
  logic res_n_nxt;
  logic leak_en_r;
  logic leak_en_nxt;
  logic irq_r;
  logic irq_nxt;
  logic mon_r;
  logic mon_nxt;
  logic bias_r;
  logic bias_nxt;
  pcd_cmpb_pos_t b_pos_r;
  pcd_cmpb_pos_t b_pos_nxt;
  pcd_cmp_neg_t b_neg_r;
  pcd_cmp_neg_t b_neg_nxt;
  pcd_cmpa_pos_t a_pos_r;
  pcd_cmpa_pos_t a_pos_nxt;
  pcd_cmp_neg_t a_neg_r;
  pcd_cmp_neg_t a_neg_nxt;

  // ******************************************************************
  // Address decode
  // ******************************************************************
  always_comb begin
    idx = paddr[15:2];
    aligned = (paddr[1:0] == 2'h0);
    hit_cry1 = aligned && (idx == `PCD_IDX_CRY1);
    hit_cry2 = aligned && (idx == `PCD_IDX_CRY2);
    hit_div = aligned && (idx == `PCD_IDX_DIV);
    hit_divstat = aligned && (idx == `PCD_IDX_DIVSTAT);
    hit_anstat = aligned && (idx == `PCD_IDX_ANSTAT);
    mapped = hit_cry1 || hit_cry2 || hit_div || hit_divstat || hit_anstat;
    read_only = hit_divstat || hit_anstat;
  end

  // ******************************************************************
  // Bus phase tracking
  // ******************************************************************
  // Ready comes in the cycle after setup, so there are no wait states.
  always_comb begin
    setup_phase = psel && !penable;
    case (state_r)
      PCD_IDLE: state_nxt = setup_phase ? PCD_SETUP : PCD_IDLE;
      PCD_SETUP: state_nxt = (psel && penable) ? PCD_ACCESS : PCD_IDLE;
      PCD_ACCESS: state_nxt = setup_phase ? PCD_SETUP : PCD_IDLE;
      default: state_nxt = PCD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PCD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ******************************************************************
  // Read data and error, captured in the setup cycle
  // ******************************************************************
  // Writes and refused accesses return zero read data.
  always_comb begin
    prdata_nxt = prdata_r;
    err_nxt = err_r;
    if (setup_phase) begin
      err_nxt = !mapped || (pwrite && read_only);
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_cry1) begin
          prdata_nxt[7:0] = cry1_r;
        end else if (hit_cry2) begin
          prdata_nxt[7:0] = cry2_r;
        end else if (hit_div) begin
          prdata_nxt[7:0] = div_r;
        end else if (hit_divstat) begin
          prdata_nxt[2:0] = act_shift;
        end else if (hit_anstat) begin
          prdata_nxt[`PCD_ANST_OSC_BIT] = osc_rc_active;
          prdata_nxt[`PCD_ANST_CMPB_BIT] = comp_b_out;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign pready = (state_r == PCD_SETUP);
  assign pslverr = (state_r == PCD_SETUP) && err_r;
  assign prdata = prdata_r;

  // ******************************************************************
  // Register writes
  // ******************************************************************
  always_comb begin
    wr_en = psel && penable && pwrite && (state_r == PCD_SETUP) &&
            !err_r && pstrb[0];
    cry1_nxt = cry1_r;
    cry2_nxt = cry2_r;
    div_nxt = div_r;
    if (wr_en && hit_cry1) begin
      cry1_nxt = pwdata[7:0];
    end
    if (wr_en && hit_cry2) begin
      cry2_nxt = pwdata[7:0];
    end
    if (wr_en && hit_div) begin
      div_nxt = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cry1_r <= `PCD_CRY1_RST;
      cry2_r <= `PCD_CRY2_RST;
      div_r <= `PCD_DIV_RST;
    end else begin
      cry1_r <= cry1_nxt;
      cry2_r <= cry2_nxt;
      div_r <= div_nxt;
    end
  end

  // ******************************************************************
  // Trim outputs
  // ******************************************************************
  // Trims follow the next register value, so they move at the write edge.
  // This keeps every trim in step with the register that software reads.
  always_comb begin
    cap_nxt = cry1_nxt[`PCD_CRY1_CAP_BIT];
    res_nxt = cry1_nxt[2:0];
    res_p_nxt = cry1_nxt[`PCD_CRY1_RES_P_BIT];
    res_n_nxt = (cry1_nxt[1:0] == `PCD_RES_N_CODE);
    leak_en_nxt = cry2_nxt[`PCD_CRY2_LEAK_BIT];
    irq_nxt = leak_en_nxt && ref_leak_detected;
    mon_nxt = cry2_nxt[`PCD_CRY2_MON_BIT];
    bias_nxt = cry2_nxt[`PCD_CRY2_BIAS_BIT];
    route_b = pcd_cmp_route(cry2_nxt[`PCD_CRY2_CMPB_HI:`PCD_CRY2_CMPB_LO]);
    route_a = pcd_cmp_route(cry2_nxt[`PCD_CRY2_CMPA_HI:`PCD_CRY2_CMPA_LO]);
    b_pos_nxt = pcd_cmpb_pos_t'(route_b[1]);
    b_neg_nxt = pcd_cmp_neg_t'(route_b[0]);
    a_pos_nxt = pcd_cmpa_pos_t'(route_a[1]);
    a_neg_nxt = pcd_cmp_neg_t'(route_a[0]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= 1'b0;
      res_r <= 3'h0;
      res_p_r <= 1'b0;
      res_n_r <= 1'b0;
      leak_en_r <= 1'b0;
      irq_r <= 1'b0;
      mon_r <= 1'b0;
      bias_r <= 1'b0;
      b_pos_r <= PCD_B_POS_MET_TWO;
      b_neg_r <= PCD_NEG_LOW_POWER_REFERENCE;
      a_pos_r <= PCD_A_POS_PPIN;
      a_neg_r <= PCD_NEG_LOW_POWER_REFERENCE;
    end else begin
      cap_r <= cap_nxt;
      res_r <= res_nxt;
      res_p_r <= res_p_nxt;
      res_n_r <= res_n_nxt;
      leak_en_r <= leak_en_nxt;
      irq_r <= irq_nxt;
      mon_r <= mon_nxt;
      bias_r <= bias_nxt;
      b_pos_r <= b_pos_nxt;
      b_neg_r <= b_neg_nxt;
      a_pos_r <= a_pos_nxt;
      a_neg_r <= a_neg_nxt;
    end
  end

  assign load_cap_reduce = cap_r;
  assign osc_resistor_trim = res_r;
  assign osc_res_p_add = res_p_r;
  assign osc_res_n_add = res_n_r;
  assign ref_leak_detect_en = leak_en_r;
  assign ref_leak_irq = irq_r;
  assign osc_monitor_en = mon_r;
  assign comp_b_bias_sel = bias_r;
  assign comp_b_pos_sel = b_pos_r;
  assign comp_b_neg_sel = b_neg_r;
  assign comp_a_pos_sel = a_pos_r;
  assign comp_a_neg_sel = a_neg_r;

  // ******************************************************************
  // Peripheral clock divider
  // ******************************************************************
  // The counter takes a new ratio only at the end of a divided period.
  pcd_clkdiv u_clkdiv (
    .pclk(pclk),
    .presetn(presetn),
    .req_shift(pcd_div_shift(div_r)),
    .act_shift(act_shift),
    .periph_clk(periph_clk),
    .periph_tick(periph_tick)
  );
endmodule

// ==== bench/pcd_sva.sv ====
// Checker of the divider and trim block, watching its ports.
// Assumes a bind to pcd_top and pcd_regs.svh on the include path.
`include "pcd_regs.svh"
module pcd_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_rc_active,
  input wire logic ref_leak_detected,
  input wire logic periph_clk,
  input wire logic periph_tick,
  input wire logic load_cap_reduce,
  input wire logic [2:0] osc_resistor_trim,
  input wire logic osc_res_p_add,
  input wire logic osc_res_n_add,
  input wire logic ref_leak_detect_en,
  input wire logic ref_leak_irq,
  input wire logic osc_monitor_en,
  input wire pcd_pkg::pcd_cmpa_pos_t comp_a_pos_sel,
  input wire pcd_pkg::pcd_cmp_neg_t comp_a_neg_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcd_pkg::*;
  localparam logic [15:0] A1 = {`PCD_IDX_CRY1, 2'b00};
  localparam logic [15:0] A2 = {`PCD_IDX_CRY2, 2'b00};
  localparam logic [15:0] AS = {`PCD_IDX_ANSTAT, 2'b00};
  logic wr;
  assign wr = psel & penable & pwrite & pready & !pslverr & pstrb[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_ready; psel && !penable |=> pready; endproperty
  property p_bad; psel && penable && paddr[1:0] != 2'b00 |-> pslverr;
  endproperty
  property p_cap; wr && paddr == A1 |=> load_cap_reduce == $past(pwdata[4]);
  endproperty
  property p_res; wr && paddr == A1 |=> osc_res_p_add == $past(pwdata[2])
    && osc_res_n_add == ($past(pwdata[1:0]) == 2'b10); endproperty
  property p_mon; wr && paddr == A2 |=> osc_monitor_en == $past(pwdata[5])
    && ref_leak_detect_en == $past(pwdata[7]); endproperty
  property p_irq;
    ref_leak_irq == (ref_leak_detect_en && $past(ref_leak_detected));
  endproperty
  property p_cmpa; wr && paddr == A2 |=> comp_a_neg_sel == $past(pwdata[1])
    && comp_a_pos_sel == ($past(pwdata[1:0]) == 2'b01); endproperty
  property p_osc; psel && !penable && paddr == AS |=>
    prdata[7] == $past(osc_rc_active); endproperty
  property p_rise; $rose(periph_clk) |-> $past(periph_tick); endproperty
  property p_fall; $fell(periph_clk) |-> !$past(periph_tick); endproperty
  a_ready: assert property (p_ready) else $error("No ready after setup.");
  a_bad: assert property (p_bad) else $error("Unaligned access accepted.");
  a_cap: assert property (p_cap) else $error("Load trim wrong.");
  a_res: assert property (p_res) else $error("Resistor trim wrong.");
  a_mon: assert property (p_mon) else $error("Monitor wrong.");
  a_irq: assert property (p_irq) else $error("Leak irq wrong.");
  a_cmpa: assert property (p_cmpa) else $error("Routing A wrong.");
  a_osc: assert property (p_osc) else $error("Osc status wrong.");
  a_rise: assert property (p_rise) else $error("Early rise.");
  a_fall: assert property (p_fall) else $error("Fall at boundary.");
  c_wr2: cover property (wr && paddr == A2);
  c_rise: cover property ($rose(periph_clk));
  c_irq: cover property (ref_leak_irq);
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench of the divider and trim block over APB.
// Assumes pcd_pkg, pcd_top and pcd_sva are compiled before it.
`include "pcd_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] A1 = {`PCD_IDX_CRY1, 2'b00};
  localparam logic [15:0] A2 = {`PCD_IDX_CRY2, 2'b00};
  localparam logic [15:0] AD = {`PCD_IDX_DIV, 2'b00};
  localparam logic [15:0] AT = {`PCD_IDX_DIVSTAT, 2'b00};
  localparam logic [15:0] AS = {`PCD_IDX_ANSTAT, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic osc_rc_active = 0, comp_b_out = 0, ref_leak_detected = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, periph_clk, periph_tick, load_cap_reduce, err;
  logic osc_res_p_add, osc_res_n_add, ref_leak_detect_en, ref_leak_irq;
  logic osc_monitor_en, comp_b_bias_sel, cb_pos, cb_neg, ca_pos, ca_neg;
  logic [2:0] osc_resistor_trim, sh;
  logic [7:0] v, code;
  int bad_count = 0, samples_checked = 0, cyc = 0, i, n, h;
  pcd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_rc_active(osc_rc_active), .comp_b_out(comp_b_out),
    .ref_leak_detected(ref_leak_detected), .periph_clk(periph_clk),
    .periph_tick(periph_tick), .load_cap_reduce(load_cap_reduce),
    .osc_resistor_trim(osc_resistor_trim), .osc_res_p_add(osc_res_p_add),
    .osc_res_n_add(osc_res_n_add), .ref_leak_detect_en(ref_leak_detect_en),
    .ref_leak_irq(ref_leak_irq), .osc_monitor_en(osc_monitor_en),
    .comp_b_bias_sel(comp_b_bias_sel), .comp_b_pos_sel(cb_pos),
    .comp_b_neg_sel(cb_neg), .comp_a_pos_sel(ca_pos),
    .comp_a_neg_sel(ca_neg));
  // ****************************************************************
  // Clock, timeout and tasks
  // ****************************************************************
  initial begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task finish_test();
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task xfer(input logic [15:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hF);
    @(negedge pclk);
  endtask
  task rdchk(input logic [15:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, 4'h0);
    check(rd, e);
    check(err, 0);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rdchk(A1, 0);
    rdchk(A2, 0);
    rdchk(AD, 0);
    check(osc_monitor_en, 0);
    check(periph_clk, 1);
    // Reserved bits are kept zero on every write.
    for (i = 0; i < 16; i++) begin
      v = {3'b0, i[3], 1'b0, i[2:0]};
      wr(A1, v);
      check({load_cap_reduce, osc_res_p_add}, {i[3], i[2]});
      check({osc_res_n_add, osc_resistor_trim}, {i[1:0] == 2'b10, i[2:0]});
      rdchk(A1, v);
      v = {i[0], 1'b0, i[1], i[2], i[3:2], i[1:0]};
      wr(A2, v);
      check({ref_leak_detect_en, osc_monitor_en}, {i[0], i[1]});
      check(comp_b_bias_sel, i[2]);
      check({cb_pos, cb_neg}, {i[3:2] == 2'b01, i[3]});
      check({ca_pos, ca_neg}, {i[1:0] == 2'b01, i[1]});
      rdchk(A2, v);
    end
    xfer(A1, 1'b1, 32'hFF, 4'h0);
    check(err, 0);
    rdchk(A1, 32'h17);
    xfer(16'h0004, 1'b0, 32'h0, 4'h0);
    check(err, 1);
    check(rd, 0);
    xfer(AS, 1'b1, 32'h0, 4'hF);
    check(err, 1);
    xfer(A1 + 16'h0001, 1'b1, 32'h0, 4'hF);
    check(err, 1);
    wr(A2, 32'h80);
    @(posedge pclk);
    ref_leak_detected <= 1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(ref_leak_irq, 1);
    wr(A2, 32'h00);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(ref_leak_irq, 0);
    @(posedge pclk);
    for (i = 0; i < 4; i++) begin
      osc_rc_active <= i[0];
      comp_b_out <= i[1];
      xfer(AS, 1'b0, 32'h0, 4'h0);
      check(rd & 32'hA0, {i[0], 1'b0, i[1], 5'b0});
    end
    // Codes 0 to 4 give ratios 1 to 16; codes 05 and FF give ratio 1.
    for (i = 0; i < 7; i++) begin
      code = (i == 5) ? 8'h05 : (i == 6) ? 8'hFF : i[7:0];
      sh = (i < 5) ? i[2:0] : 3'h0;
      wr(AD, code);
      n = 0;
      do begin
        xfer(AT, 1'b0, 32'h0, 4'h0);
        n++;
      end while (rd[2:0] !== sh && n < 40);
      check(rd[2:0], sh);
      @(negedge pclk);
      while (periph_tick !== 1'b1) @(negedge pclk);
      n = 0;
      h = 0;
      do begin
        @(negedge pclk);
        n++;
        h += periph_clk;
      end while (periph_tick !== 1'b1 && n < 40);
      check(n, 1 << sh);
      check(h, (sh == 0) ? 1 : (1 << sh) / 2);
    end
    wr(A1, 32'h03); // Real-time clock trim with the monitor on.
    wr(A2, 32'h20);
    check({osc_resistor_trim, osc_monitor_en}, 4'h7);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdchk(A1, 0);
    check(osc_monitor_en, 0);
    finish_test();
  end
endmodule
bind pcd_top pcd_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_rc_active(osc_rc_active), .ref_leak_detected(ref_leak_detected),
  .periph_clk(periph_clk), .periph_tick(periph_tick),
  .load_cap_reduce(load_cap_reduce), .osc_resistor_trim(osc_resistor_trim),
  .osc_res_p_add(osc_res_p_add), .osc_res_n_add(osc_res_n_add),
  .ref_leak_detect_en(ref_leak_detect_en), .ref_leak_irq(ref_leak_irq),
  .osc_monitor_en(osc_monitor_en), .comp_a_pos_sel(comp_a_pos_sel),
  .comp_a_neg_sel(comp_a_neg_sel));
